// ===== sfp_pkg.sv
// Shared constants, helpers and types for the serial frame link
package sfp_pkg;
	localparam int FRAME_BITS = 16;
	localparam int PFX_MSB = 15;
	localparam int PFX_LSB = 14;
	localparam int ADDR_MSB = 13;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int TAIL_MSB = 1;
	localparam int TER_DIAG_BIT = 10;
	localparam int TER_INPUT_STATUS_WORD_BIT = 7;
	localparam int INPUT_STATUS_WORD_IN_MSB = 1;
	localparam logic [4:0] CNT_FIRST = 5'h01;
	localparam logic [4:0] CNT_MIN = 5'h10;
	localparam logic [4:0] CNT_WRAP = 5'h17;
	localparam logic [4:0] TX_LAST = 5'h10;
	localparam logic [2:0] BYTE_MOD_ZERO = 3'h0;
	localparam logic [1:0] PFX_DIAG = 2'h0;
	localparam logic [1:0] PFX_READ = 2'h1;
	localparam logic [1:0] PFX_WRITE = 2'h2;
	localparam logic [1:0] READ_TAIL = 2'h2;
	localparam logic [1:0] RESP_PFX = 2'h2;
	localparam logic [5:0] INPUT_STATUS_WORD_ADDR = 6'h06;
	localparam logic [15:0] INPUT_STATUS_WORD_RESET_WORD = 16'h8680;
	localparam logic [63:0] READ_MAP = 64'h0000000000000071;
	localparam logic [63:0] WRITE_MAP = 64'h0000000000000031;
	localparam int SYS_PERIOD_PS = 5000;
	localparam int SCLK_PERIOD_NS = 200;
	localparam int LEAD_NS = 200;
	localparam int LAG_NS = 200;
	localparam int GAP_NS = 250;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	localparam logic [7:0] HALF_CYC = 8'(ns_to_cyc(SCLK_PERIOD_NS / 2));
	localparam logic [7:0] LEAD_CYC = 8'(ns_to_cyc(LEAD_NS));
	localparam logic [7:0] LAG_CYC = 8'(ns_to_cyc(LAG_NS));
	localparam logic [7:0] GAP_CYC = 8'(ns_to_cyc(GAP_NS));

	function automatic logic [4:0] cnt_step(input logic [4:0] c);
		return (c == CNT_WRAP) ? CNT_MIN : c + CNT_FIRST;
	endfunction : cnt_step

	function automatic logic len_ok(input logic [4:0] c);
		return (c >= CNT_MIN) && (c[2:0] == BYTE_MOD_ZERO);
	endfunction : len_ok

	function automatic logic map_hit(input logic [63:0] m,
		input logic [5:0] a);
		return m[a];
	endfunction : map_hit

	function automatic logic [15:0] build_diag(input logic [14:0] d,
		input logic frame_error_flag);
		logic [15:0] w;
		w = {1'b0, d};
		w[TER_DIAG_BIT] = frame_error_flag;
		return w;
	endfunction : build_diag

	function automatic logic [15:0] build_input_status_word(input logic frame_error_flag,
		input logic [1:0] pins);
		logic [15:0] w;
		w = {RESP_PFX, INPUT_STATUS_WORD_ADDR, 8'h00};
		w[TER_INPUT_STATUS_WORD_BIT] = frame_error_flag;
		w[INPUT_STATUS_WORD_IN_MSB:0] = pins;
		return w;
	endfunction : build_input_status_word

	typedef enum logic [2:0] {
		DS_IDLE = 3'b001,
		DS_DECODE = 3'b010,
		DS_LOAD = 3'b100
	} sfp_dev_state_t;

	typedef enum logic [2:0] {
		RK_DIAG = 3'b001,
		RK_REG = 3'b010,
		RK_INPUT_STATUS_WORD = 3'b100
	} sfp_resp_t;

	typedef enum logic [5:0] {
		HS_IDLE = 6'b000001,
		HS_LEAD = 6'b000010,
		HS_HIGH = 6'b000100,
		HS_LOW = 6'b001000,
		HS_LAG = 6'b010000,
		HS_GAP = 6'b100000
	} sfp_host_state_t;
endpackage : sfp_pkg

// ===== sfp_link_if.sv
// Serial link wires between the host end and the device end
`timescale 1ns/1ps
interface sfp_link_if;
	logic sclk;
	logic select_low;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;

	// Undriven output line idles high
	assign so_line = so_oe ? so : 1'b1;

	modport dev (
		input sclk,
		input select_low,
		input si,
		output so,
		output so_oe
	);

	modport host (
		output sclk,
		output select_low,
		output si,
		input so_line
	);
endinterface : sfp_link_if

// ===== sfp_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sfp_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Level
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= 1'b1;
			q <= 1'b1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sfp_sync

// ===== sfp_device.sv
// Device end: frame capture on the link clock, answers built on clk_sys
// Behaviour
// - Commands arrive on si, answers leave on so.
// - Answer only in the next transfer.
// - Host remembers its previous command.
// - Bad clock count gives special next answer.
// - After reset first answer is special.
// - Write prefix 11 is a syntax error.
// - Read prefix 00 is a syntax error.
// - Unmapped address is a syntax error.
// - Write frame answered with standard diagnosis.
// - Read answered with 10, address, content.
// - Defined answer in the immediately next transfer.
// - One bit shifted per clock, sixteen-bit frame.
// - Host raises select to end transfer.
// - Error flag clear only on valid count.
// - Reset: status word first, then diagnosis.
`timescale 1ns/1ps
module sfp_device (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Link
	sfp_link_if.dev link,
	// Register access toward the user
	output logic wr_valid,
	output logic [5:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [5:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Status inputs
	input wire logic [14:0] diag_in,
	input wire logic [1:0] in_state,
	input wire logic soft_reset,
	// Status outputs
	output logic frame_error,
	output logic syntax_error
);
	// Link clock domain
	logic rx_first;
	logic tx_first;
	logic [15:0] rx_sh;
	logic [4:0] bit_cnt;
	logic [4:0] tx_cnt;
	logic [4:0] tx_idx;
	logic so_q;
	// System clock domain
	logic sel_s;
	logic sel_q;
	logic frame_end;
	logic [15:0] cmd;
	logic frame_ok;
	logic frame_error_flag;
	logic post_reset;
	logic [15:0] tx_word;
	sfp_pkg::sfp_dev_state_t state;
	sfp_pkg::sfp_resp_t kind;
	sfp_pkg::sfp_resp_t next_kind;
	logic next_wr;
	logic next_syn;
	logic [1:0] pfx;
	logic [5:0] addr;

	// Frame start marker for the capture side
	always_ff @(negedge link.sclk or negedge arst_n
		or posedge link.select_low) begin
		if (!arst_n) begin
			rx_first <= 1'b1;
		end else if (link.select_low) begin
			rx_first <= 1'b1;
		end else begin
			rx_first <= 1'b0;
		end
	end

	// Capture on falling clock, count clocks of this frame
	always_ff @(negedge link.sclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sh <= 16'h0000;
			bit_cnt <= 5'h00;
		end else if (!link.select_low) begin
			rx_sh <= {rx_sh[sfp_pkg::FRAME_BITS-2:0], link.si};
			bit_cnt <= rx_first ? sfp_pkg::CNT_FIRST
				: sfp_pkg::cnt_step(bit_cnt);
		end
	end

	// Frame start marker for the launch side
	always_ff @(posedge link.sclk or negedge arst_n
		or posedge link.select_low) begin
		if (!arst_n) begin
			tx_first <= 1'b1;
		end else if (link.select_low) begin
			tx_first <= 1'b1;
		end else begin
			tx_first <= 1'b0;
		end
	end

	assign tx_idx = tx_first ? 5'h00 : tx_cnt;

	// Launch on rising clock; past sixteen bits pass the input through
	always_ff @(posedge link.sclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_cnt <= 5'h00;
			so_q <= 1'b0;
		end else if (!link.select_low) begin
			if (tx_idx < sfp_pkg::TX_LAST) begin
				so_q <= tx_word[4'(sfp_pkg::FRAME_BITS - 1) - tx_idx[3:0]];
				tx_cnt <= tx_idx + sfp_pkg::CNT_FIRST;
			end else begin
				so_q <= rx_sh[sfp_pkg::FRAME_BITS-1];
				tx_cnt <= sfp_pkg::TX_LAST;
			end
		end
	end

	// First bit shows as soon as select falls
	assign link.so = tx_first ? tx_word[sfp_pkg::FRAME_BITS-1] : so_q;
	assign link.so_oe = ~link.select_low;

	sfp_sync u_sel_sync (
		.clk(clk_sys),
		.arst_n(arst_n),
		.d(link.select_low),
		.q(sel_s)
	);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= 1'b1;
		end else begin
			sel_q <= sel_s;
		end
	end

	// Frame taken once select is back high; link clock is then still
	assign frame_end = sel_s & ~sel_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmd <= 16'h0000;
			frame_ok <= 1'b0;
		end else if (frame_end) begin
			cmd <= rx_sh;
			frame_ok <= sfp_pkg::len_ok(bit_cnt);
		end
	end
	assign pfx = cmd[sfp_pkg::PFX_MSB:sfp_pkg::PFX_LSB];
	assign addr = cmd[sfp_pkg::ADDR_MSB:sfp_pkg::ADDR_LSB];

	// Command decode
	always_comb begin
		next_kind = sfp_pkg::RK_DIAG;
		next_wr = 1'b0;
		next_syn = 1'b0;
		if (pfx == sfp_pkg::PFX_WRITE) begin
			if (sfp_pkg::map_hit(sfp_pkg::WRITE_MAP, addr)) begin
				next_wr = 1'b1;
			end else begin
				next_syn = 1'b1;
			end
		end else if (pfx == sfp_pkg::PFX_READ) begin
			if (cmd[sfp_pkg::TAIL_MSB:0] == sfp_pkg::READ_TAIL
				&& sfp_pkg::map_hit(sfp_pkg::READ_MAP, addr)) begin
				next_kind = (addr == sfp_pkg::INPUT_STATUS_WORD_ADDR) ? sfp_pkg::RK_INPUT_STATUS_WORD
					: sfp_pkg::RK_REG;
			end else begin
				next_syn = 1'b1;
			end
		end else if (pfx == sfp_pkg::PFX_DIAG) begin
			next_syn = cmd[sfp_pkg::TAIL_MSB:0] == sfp_pkg::READ_TAIL;
		end else begin
			next_syn = 1'b1;
		end
		if (!frame_ok || post_reset || next_syn) begin
			next_kind = sfp_pkg::RK_DIAG;
			next_wr = 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= sfp_pkg::DS_IDLE;
		end else begin
			unique case (state)
				sfp_pkg::DS_IDLE: begin
					if (frame_end) begin
						state <= sfp_pkg::DS_DECODE;
					end
				end
				sfp_pkg::DS_DECODE: begin
					state <= sfp_pkg::DS_LOAD;
				end
				sfp_pkg::DS_LOAD: begin
					state <= sfp_pkg::DS_IDLE;
				end
				default: begin
					state <= sfp_pkg::DS_IDLE;
				end
			endcase
		end
	end

	// Decode results and user strobes
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			kind <= sfp_pkg::RK_DIAG;
			wr_valid <= 1'b0;
			wr_addr <= 6'h00;
			wr_data <= 8'h00;
			rd_addr <= 6'h00;
			syntax_error <= 1'b0;
		end else begin
			wr_valid <= 1'b0;
			syntax_error <= 1'b0;
			if (state == sfp_pkg::DS_DECODE) begin
				kind <= next_kind;
				wr_valid <= next_wr;
				wr_addr <= addr;
				wr_data <= cmd[sfp_pkg::DATA_MSB:0];
				rd_addr <= addr;
				syntax_error <= next_syn & frame_ok;
			end
		end
	end

	// Error flag and post-reset marker
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			frame_error_flag <= 1'b1;
			post_reset <= 1'b1;
		end else if (soft_reset) begin
			frame_error_flag <= 1'b1;
			post_reset <= 1'b1;
		end else if (state == sfp_pkg::DS_DECODE) begin
			frame_error_flag <= ~frame_ok;
			post_reset <= 1'b0;
		end
	end
	assign frame_error = frame_error_flag;

	// Answer word, stable for the whole next transfer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_word <= sfp_pkg::INPUT_STATUS_WORD_RESET_WORD;
		end else if (soft_reset) begin
			tx_word <= sfp_pkg::build_input_status_word(1'b1, in_state);
		end else if (state == sfp_pkg::DS_LOAD) begin
			unique case (kind)
				sfp_pkg::RK_DIAG: begin
					tx_word <= sfp_pkg::build_diag(diag_in, frame_error_flag);
				end
				sfp_pkg::RK_REG: begin
					tx_word <= {sfp_pkg::RESP_PFX, rd_addr, rd_data};
				end
				sfp_pkg::RK_INPUT_STATUS_WORD: begin
					tx_word <= sfp_pkg::build_input_status_word(frame_error_flag, in_state);
				end
				default: begin
					tx_word <= sfp_pkg::build_diag(diag_in, frame_error_flag);
				end
			endcase
		end
	end
	// Loaded between frames or on soft_reset, so each answer goes out next transfer
endmodule : sfp_device

// ===== sfp_host.sv
// Host end: makes the link clock by division and runs one frame per request
`timescale 1ns/1ps
module sfp_host (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Link
	sfp_link_if.host link,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [15:0] req_word,
	input wire logic [5:0] req_len,
	// Answer
	output logic resp_valid,
	output logic [15:0] resp_word,
	output logic [15:0] resp_prev_cmd
);
	sfp_pkg::sfp_host_state_t state;
	logic [7:0] timer;
	logic [5:0] bits_left;
	logic [15:0] tx_sh;
	logic [15:0] rx_sh;
	logic [15:0] cur_cmd;
	logic [15:0] last_cmd;
	logic so_s;
	logic sclk;
	logic select_low;
	logic si;

	sfp_sync u_so_sync (
		.clk(clk_sys),
		.arst_n(arst_n),
		.d(link.so_line),
		.q(so_s)
	);

	assign link.sclk = sclk;
	assign link.select_low = select_low;
	assign link.si = si;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= sfp_pkg::HS_IDLE;
			timer <= 8'h00;
			bits_left <= 6'h00;
			tx_sh <= 16'h0000;
			rx_sh <= 16'h0000;
			cur_cmd <= 16'h0000;
			sclk <= 1'b0;
			select_low <= 1'b1;
			si <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			unique case (state)
				sfp_pkg::HS_IDLE: begin
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						select_low <= 1'b0;
						tx_sh <= req_word;
						cur_cmd <= req_word;
						bits_left <= req_len;
						timer <= sfp_pkg::LEAD_CYC - 8'h01;
						state <= sfp_pkg::HS_LEAD;
					end
				end
				sfp_pkg::HS_LEAD: begin
					timer <= timer - 8'h01;
					if (timer == 8'h00) begin
						if (bits_left == 6'h00) begin
							timer <= sfp_pkg::LAG_CYC - 8'h01;
							state <= sfp_pkg::HS_LAG;
						end else begin
							sclk <= 1'b1;
							si <= tx_sh[sfp_pkg::FRAME_BITS-1];
							tx_sh <= {tx_sh[sfp_pkg::FRAME_BITS-2:0], 1'b0};
							timer <= sfp_pkg::HALF_CYC - 8'h01;
							state <= sfp_pkg::HS_HIGH;
						end
					end
				end
				sfp_pkg::HS_HIGH: begin
					timer <= timer - 8'h01;
					if (timer == 8'h00) begin
						sclk <= 1'b0;
						bits_left <= bits_left - 6'h01;
						timer <= sfp_pkg::HALF_CYC - 8'h01;
						state <= sfp_pkg::HS_LOW;
					end
				end
				sfp_pkg::HS_LOW: begin
					timer <= timer - 8'h01;
					if (timer == 8'h00) begin
						rx_sh <= {rx_sh[sfp_pkg::FRAME_BITS-2:0], so_s};
						if (bits_left != 6'h00) begin
							sclk <= 1'b1;
							si <= tx_sh[sfp_pkg::FRAME_BITS-1];
							tx_sh <= {tx_sh[sfp_pkg::FRAME_BITS-2:0], 1'b0};
							timer <= sfp_pkg::HALF_CYC - 8'h01;
							state <= sfp_pkg::HS_HIGH;
						end else begin
							timer <= sfp_pkg::LAG_CYC - 8'h01;
							state <= sfp_pkg::HS_LAG;
						end
					end
				end
				sfp_pkg::HS_LAG: begin
					timer <= timer - 8'h01;
					if (timer == 8'h00) begin
						select_low <= 1'b1;
						si <= 1'b0;
						timer <= sfp_pkg::GAP_CYC - 8'h01;
						state <= sfp_pkg::HS_GAP;
					end
				end
				sfp_pkg::HS_GAP: begin
					timer <= timer - 8'h01;
					if (timer == 8'h00) begin
						req_ready <= 1'b1;
						state <= sfp_pkg::HS_IDLE;
					end
				end
				default: begin
					state <= sfp_pkg::HS_IDLE;
				end
			endcase
		end
	end

	// Answer of each frame paired with the command it answers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			resp_valid <= 1'b0;
			resp_word <= 16'h0000;
			resp_prev_cmd <= 16'h0000;
			last_cmd <= 16'h0000;
		end else begin
			resp_valid <= 1'b0;
			if (state == sfp_pkg::HS_LAG && timer == 8'h00) begin
				resp_valid <= 1'b1;
				resp_word <= rx_sh;
				resp_prev_cmd <= last_cmd;
				last_cmd <= cur_cmd;
			end
		end
	end
endmodule : sfp_host

// ===== sfp_link_sva.sv
// Timing and framing checks on the serial link wires
`timescale 1ns/1ps
module sfp_link_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Link
	input wire logic sclk,
	input wire logic select_low,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_line
);
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;
	logic [7:0] fall_cnt;
	logic seen_rise;

	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Cycles with select high or low
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hi_cnt <= 8'hFF;
			lo_cnt <= 8'h00;
		end else begin
			hi_cnt <= select_low ? hi_cnt + {7'h00, hi_cnt != 8'hFF} : 8'h00;
			lo_cnt <= select_low ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
		end
	end

	// Cycles since the link clock was last high
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fall_cnt <= 8'hFF;
		end else begin
			fall_cnt <= sclk ? 8'h00 : fall_cnt + {7'h00, fall_cnt != 8'hFF};
		end
	end

	// First link clock rise of a frame
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			seen_rise <= 1'b0;
		end else begin
			seen_rise <= select_low ? 1'b0 : (seen_rise | sclk);
		end
	end

	oe_tracks_select_a: assert property (so_oe == !select_low)
		else $error("so_oe does not follow select");
	idle_lines_a: assert property (select_low |-> !sclk && so_line)
		else $error("link clock or output line not idle");
	so_launch_a: assert property (
		!select_low && !$past(select_low) && $changed(so) |-> $rose(sclk))
		else $error("so changed off a rising link clock");
	si_hold_a: assert property (
		$fell(sclk) |-> $stable(si) ##1 $stable(si)[*3])
		else $error("si moved around falling link clock");
	lead_time_a: assert property (
		$rose(sclk) && !seen_rise |-> lo_cnt >= 8'h28)
		else $error("lead time too short");
	lag_time_a: assert property ($rose(select_low) |-> fall_cnt >= 8'h28)
		else $error("lag time too short");
	gap_time_a: assert property ($fell(select_low) |-> hi_cnt >= 8'h32)
		else $error("transfer gap too short");
	clock_halves_a: assert property (
		$changed(sclk) |-> $past(sclk, 15) == $past(sclk))
		else $error("link clock half period too short");
endmodule : sfp_link_sva

// ===== spi_frame_protocol_slave_tb.sv
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module spi_frame_protocol_slave_tb;
	logic clk_sys;
	logic arst_n;
	logic req_valid;
	logic req_ready;
	logic [15:0] req_word;
	logic [5:0] req_len;
	logic resp_valid;
	logic [15:0] resp_word;
	logic [15:0] resp_prev_cmd;
	logic wr_valid;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic [5:0] rd_addr;
	logic [7:0] rd_data;
	logic [14:0] diag_in;
	logic [1:0] in_state;
	logic soft_reset;
	logic frame_error;
	logic syntax_error;
	logic [7:0] regs [64];
	logic [7:0] syn_cnt;
	logic [7:0] wr_cnt;
	int errors;
	int checks_done;

	sfp_link_if lnk ();
	sfp_host sfp_host_input_status_word (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(lnk.host), .req_valid(req_valid), .req_ready(req_ready),
		.req_word(req_word), .req_len(req_len), .resp_valid(resp_valid),
		.resp_word(resp_word), .resp_prev_cmd(resp_prev_cmd));
	sfp_device sfp_device_input_status_word (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(lnk.dev), .wr_valid(wr_valid), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
		.diag_in(diag_in), .in_state(in_state), .soft_reset(soft_reset),
		.frame_error(frame_error), .syntax_error(syntax_error));
	sfp_link_sva sfp_link_sva_input_status_word (.clk_sys(clk_sys), .arst_n(arst_n),
		.sclk(lnk.sclk), .select_low(lnk.select_low), .si(lnk.si),
		.so(lnk.so), .so_oe(lnk.so_oe), .so_line(lnk.so_line));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// User register file and event counters
	assign rd_data = regs[rd_addr];
	always @(posedge clk_sys) begin
		if (!arst_n) begin
			foreach (regs[i]) regs[i] <= 8'h00;
			wr_cnt <= 8'h00;
			syn_cnt <= 8'h00;
		end else begin
			if (wr_valid === 1'b1) begin
				regs[wr_addr] <= wr_data;
				wr_cnt <= wr_cnt + 8'h01;
			end
			if (syntax_error === 1'b1) syn_cnt <= syn_cnt + 8'h01;
		end
	end

	function automatic logic [15:0] diag_word(input logic frame_error_flag);
		return {1'b0, diag_in[14:11], frame_error_flag, diag_in[9:0]};
	endfunction : diag_word

	function automatic logic [15:0] stat_word(input logic frame_error_flag);
		return {2'h2, 6'h06, frame_error_flag, 5'h00, in_state};
	endfunction : stat_word

	task automatic check_word(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic exp,
		input logic got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task automatic give_verdict;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic wait_ready;
		int k;
		k = 0;
		while (req_ready !== 1'b1) begin
			@(posedge clk_sys);
			#1;
			k++;
			if (k > 400) begin
				check_bit("ready", 1'b1, req_ready);
				give_verdict();
			end
		end
	endtask : wait_ready

	// One frame; the answer seen belongs to the previous command
	task automatic xfer(input logic [15:0] w, input logic [5:0] n,
		input logic chk, input logic [15:0] exp);
		int k;
		wait_ready();
		req_word = w;
		req_len = n;
		req_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		k = 0;
		while (resp_valid !== 1'b1) begin
			@(posedge clk_sys);
			#1;
			k++;
			if (k > 2000) begin
				check_bit("answer", 1'b1, resp_valid);
				give_verdict();
			end
		end
		if (chk) check_word("answer", exp, resp_word);
	endtask : xfer

	initial begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_word = 16'h0000;
		req_len = 6'h10;
		diag_in = 15'h7C0F;
		in_state = 2'h0;
		soft_reset = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		xfer(16'h80A5, 6'h10, 1'b1, stat_word(1'b1));
		in_state = 2'h2;
		xfer(16'h843C, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h4402, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h4002, 6'h10, 1'b1, 16'h843C);
		check_word("prev_cmd", 16'h4402, resp_prev_cmd);
		xfer(16'h4602, 6'h10, 1'b1, 16'h8000);
		xfer(16'h0000, 6'h10, 1'b1, stat_word(1'b0));
		xfer(16'h85FF, 6'h0C, 1'b0, 16'h0000);
		wait_ready();
		check_bit("frame_error", 1'b1, frame_error);
		xfer(16'h0000, 6'h10, 1'b1, diag_word(1'b1));
		xfer(16'hC477, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h0402, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h4102, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h8611, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'h4400, 6'h10, 1'b1, diag_word(1'b0));
		xfer(16'hC385, 6'h18, 1'b1, {diag_in[7:0], 8'hC3});
		wait_ready();
		check_bit("frame_error", 1'b0, frame_error);
		xfer(16'h4502, 6'h10, 1'b1, diag_word(1'b0));
		wait_ready();
		soft_reset = 1'b1;
		@(posedge clk_sys);
		#1;
		soft_reset = 1'b0;
		check_bit("frame_error", 1'b1, frame_error);
		xfer(16'h4402, 6'h10, 1'b1, stat_word(1'b1));
		xfer(16'h0000, 6'h10, 1'b1, diag_word(1'b0));
		check_word("syntax_count", 16'h0005, {8'h00, syn_cnt});
		check_word("write_count", 16'h0002, {8'h00, wr_cnt});
		give_verdict();
	end
endmodule : spi_frame_protocol_slave_tb
